// File: psrc_pkg.sv
// psrc_pkg: constants for the power state and ready control block.
// assumes the 40 MHz hclk domain; nothing here is tied to a pin.
package psrc_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned HOLDOFF_MS = 50;
  localparam int unsigned HOLDOFF_CYC = (CLK_HZ / 1000) * HOLDOFF_MS;
  localparam int unsigned READY_DELAY_US = 100;
  localparam int unsigned READY_DELAY_CYC = (CLK_HZ / 1000000) * READY_DELAY_US;

  // ==========================================================
  // register map (byte offsets)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_VCODE = 8'h10;

  // ctrl fields
  localparam int CTRL_SS_DONE = 0;
  localparam int CTRL_IN_LIMITS = 1;
  localparam int CTRL_OC_EVENT = 2;

  // status fields
  localparam int ST_ENABLED = 0;
  localparam int ST_COUPLED = 1;
  localparam int ST_TWO_PHASE = 2;
  localparam int ST_LIGHT_LOAD = 3;
  localparam int ST_READY = 4;
  localparam int ST_LDO_HIGH = 5;
  localparam int ST_HOLDOFF_DONE = 6;

  // irq fields
  localparam int IRQ_READY_RISE = 0;
  localparam int IRQ_READY_FALL = 1;
  localparam int IRQ_LL_ENTER = 2;
  localparam int IRQ_LL_EXIT = 3;
  localparam int IRQ_W = 4;

  localparam int unsigned PHASES_MAX = 3;
  localparam logic [1:0] PH_NORMAL = 2'h1;
  localparam logic [1:0] PH_LIGHT = 2'h2;

  // driver1 ldo level select code: 0 = 5.75 V, 1 = 7.75 V
  localparam logic LDO_575 = 1'b0;
  localparam logic LDO_775 = 1'b1;

  typedef enum logic [2:0] {
    RDY_OFF   = 3'b001,
    RDY_WAIT  = 3'b010,
    RDY_GOOD  = 3'b100
  } psrc_rdy_e;

endpackage : psrc_pkg

// File: psrc_sync_if.sv
// psrc_sync_if: carries synchronised pin levels from the input stage.
// assumes one clock domain; all members change on hclk.
`timescale 1ns/1ps
interface psrc_sync_if;
  logic enable;
  logic psi_n;
  logic host_rst_n;
  logic host_rst_rise;
  modport src (output enable, output psi_n, output host_rst_n, output host_rst_rise);
  modport dst (input enable, input psi_n, input host_rst_n, input host_rst_rise);
endinterface : psrc_sync_if

// File: psrc_sync.sv
// psrc_sync: two-flop synchronisers for the asynchronous control pins.
// assumes pins are asynchronous to hclk; edge detect compares stages two and three.
`timescale 1ns/1ps
module psrc_sync #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] pins,
  psrc_sync_if.src so
);

  // ==========================================================
  // synchroniser stages
  logic [WIDTH-1:0] s1_q, s1_d;
  logic [WIDTH-1:0] s2_q, s2_d;
  logic [WIDTH-1:0] s3_q, s3_d;

  initial begin
    if (WIDTH != 3) $error("psrc_sync: WIDTH must be 3");
  end

  always_comb begin
    s1_d = pins;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // reset to the inactive levels: disabled, psi high, host in reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 3'h2;
      s2_q <= 3'h2;
      s3_q <= 3'h2;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  assign so.enable = s2_q[0];
  assign so.psi_n = s2_q[1];
  assign so.host_rst_n = s2_q[2];
  assign so.host_rst_rise = s2_q[2] & ~s3_q[2];

endmodule : psrc_sync

// File: psrc_holdoff.sv
// psrc_holdoff: counts the light-load hold-off after host reset release.
// assumes synchronised host reset level and its rising-edge pulse.
`timescale 1ns/1ps
module psrc_holdoff #(
  parameter int unsigned HOLDOFF_CYC = psrc_pkg::HOLDOFF_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  psrc_sync_if.dst si,
  output logic done
);

  localparam int CW = $clog2(HOLDOFF_CYC + 1);
  logic [CW-1:0] cnt_q, cnt_d;
  logic done_q, done_d;

  initial begin
    if (HOLDOFF_CYC < 1) $error("psrc_holdoff: HOLDOFF_CYC must be at least 1");
  end

  always_comb begin
    cnt_d = cnt_q;
    done_d = done_q;
    if (!si.host_rst_n) begin
      cnt_d = '0;
      done_d = 1'b0;
    end else if (si.host_rst_rise) begin
      cnt_d = '0;
      done_d = 1'b0;
    end else if (!done_q) begin
      if (cnt_q == CW'(HOLDOFF_CYC - 1)) begin
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;

endmodule : psrc_holdoff

// File: psrc_top.sv
// psrc_top: enable, straps, voltage code, ready output and light-load entry.
// assumes an AHB-Lite master on hclk; soft-start, limit and overcurrent
// status come from software registers standing in for the analog side.
//
// Summary of operation
// - controller logic held off while enable is low, runs once it is high.
// - frequency strap to bias selects coupled inductor mode, to ground standard.
// - the eight voltage code bits form the reference code.
// - undriven voltage code lines read as one through internal pull-up.
// - phase3 negative sense tied to bias selects two-phase operation.
// - with power hint low, ldo level 5.75 V or 7.75 V per soft-start strap.
// - ready released a fixed delay after soft-start, only inside limits.
// - ready pulled low on limit loss, overcurrent or disable.
// - ready held low before soft-start finishes.
// - ready is open drain: pulls low, otherwise released, never high.
// - light load entered on low power hint, left when hint goes high.
// - light-load entry allowed only while host reset is high.
// - never light load while host reset is low.
// - 50 ms wait after host reset rises before light-load entry.
// - normal state runs all active channels in continuous conduction.
// - two-phase mode fires only channels one and two; three by default.
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module psrc_top #(
  parameter int unsigned HOLDOFF_CYC = psrc_pkg::HOLDOFF_CYC,
  parameter int unsigned READY_DELAY_CYC = psrc_pkg::READY_DELAY_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic enable,
  input wire logic frequency_set_strap,
  input wire logic softstart_strap,
  input wire logic phase3_sense_neg,
  input wire logic [7:0] voltage_code_inputs,
  input wire logic [7:0] voltage_code_oe,
  input wire logic power_state_hint,
  input wire logic host_reset_n,
  output logic regulator_ready_o,
  output logic regulator_ready_oe,
  output logic [7:0] ref_code,
  output logic driver1_ldo_sel,
  output logic driver1_ldo_on,
  output logic [2:0] channel_enable,
  output logic ccm_mode,
  output logic coupled_mode,
  output logic irq
);

  localparam int RC = $clog2(READY_DELAY_CYC + 1);

  // strap capture layout: eight code lines, then the three straps
  localparam int SB_COUPLED = 8;
  localparam int SB_LDO = 9;
  localparam int SB_TWO_PHASE = 10;
  localparam int SB_W = 11;
  // channel enable patterns, bit n fires channel n+1
  localparam logic [2:0] CH_ALL = 3'h7;
  localparam logic [2:0] CH_TWO = 3'h3;
  localparam logic [2:0] CH_ONE = 3'h1;
  localparam logic [2:0] CH_NONE = 3'h0;

  initial begin
    if (READY_DELAY_CYC < 1) $error("psrc_top: READY_DELAY_CYC must be at least 1");
    if (HOLDOFF_CYC < 1) $error("psrc_top: HOLDOFF_CYC must be at least 1");
  end

  // ==========================================================
  // input stage
  psrc_sync_if sif ();
  logic holdoff_done;

  psrc_sync #(.WIDTH(3)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pins({host_reset_n, power_state_hint, enable}),
    .so(sif)
  );

  psrc_holdoff #(.HOLDOFF_CYC(HOLDOFF_CYC)) u_holdoff (
    .hclk(hclk),
    .hresetn(hresetn),
    .si(sif),
    .done(holdoff_done)
  );

  // straps and code pins are static board levels; two flops still guard them
  // reset to all ones, the level that floating lines settle to
  logic [SB_W-1:0] st1_q, st1_d;
  logic [SB_W-1:0] st2_q, st2_d;
  logic [7:0] vcode_pin;

  for (genvar i = 0; i < 8; i++) begin : g_vpull
    assign vcode_pin[i] = voltage_code_oe[i] ? voltage_code_inputs[i] : 1'b1;
  end

  always_comb begin
    st1_d = {phase3_sense_neg, softstart_strap, frequency_set_strap, vcode_pin};
    st2_d = st1_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st1_q <= '1;
      st2_q <= '1;
    end else begin
      st1_q <= st1_d;
      st2_q <= st2_d;
    end
  end

  // ==========================================================
  // bus slave
  logic ap_q, ap_d;
  logic wr_q, wr_d;
  logic [7:0] ad_q, ad_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic [psrc_pkg::IRQ_W-1:0] ist_q, ist_d;
  logic [psrc_pkg::IRQ_W-1:0] imask_q, imask_d;
  logic [31:0] rdata_q, rdata_d;
  logic [psrc_pkg::IRQ_W-1:0] ev;
  logic [6:0] status;

  always_comb begin
    ap_d = hsel & hready & htrans[1];
    wr_d = hwrite;
    ad_d = haddr[7:0];
    ctrl_d = ctrl_q;
    imask_d = imask_q;
    ist_d = ist_q;
    rdata_d = 32'h0;
    if (ap_q && wr_q) begin
      if (ad_q == psrc_pkg::ADDR_CTRL) ctrl_d = hwdata[2:0];
      if (ad_q == psrc_pkg::ADDR_IRQ_MASK) imask_d = hwdata[psrc_pkg::IRQ_W-1:0];
      if (ad_q == psrc_pkg::ADDR_IRQ_STAT) ist_d = ist_q & ~hwdata[psrc_pkg::IRQ_W-1:0];
    end
    // an event in the clearing cycle stays set
    ist_d = ist_d | ev;
    if (ap_d && !hwrite) begin
      unique case (haddr[7:0])
        psrc_pkg::ADDR_CTRL: rdata_d = {29'h0, ctrl_q};
        psrc_pkg::ADDR_STATUS: rdata_d = {25'h0, status};
        psrc_pkg::ADDR_IRQ_STAT: rdata_d = {28'h0, ist_q};
        psrc_pkg::ADDR_IRQ_MASK: rdata_d = {28'h0, imask_q};
        psrc_pkg::ADDR_VCODE: rdata_d = {24'h0, ref_code};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= 1'b0;
      wr_q <= 1'b0;
      ad_q <= 8'h00;
      ctrl_q <= 3'h0;
      ist_q <= '0;
      imask_q <= '0;
      rdata_q <= 32'h0;
    end else begin
      ap_q <= ap_d;
      wr_q <= wr_d;
      ad_q <= ad_d;
      ctrl_q <= ctrl_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // ready sequencing
  psrc_pkg::psrc_rdy_e rdy_q, rdy_d;
  logic [RC-1:0] dly_q, dly_d;
  logic ll_q, ll_d;
  logic [7:0] ref_q, ref_d;
  logic [2:0] chen_q, chen_d;
  logic ldo_sel_q, ldo_sel_d;
  logic coupled_q, coupled_d;
  logic rdy_oe_q, rdy_oe_d;
  logic irq_q, irq_d;
  logic ldo_on_d, ccm_d;
  logic en, ok;

  assign en = sif.enable;
  assign ok = ctrl_q[psrc_pkg::CTRL_IN_LIMITS] & ~ctrl_q[psrc_pkg::CTRL_OC_EVENT];

  always_comb begin
    rdy_d = rdy_q;
    dly_d = dly_q;
    unique case (rdy_q)
      psrc_pkg::RDY_OFF: begin
        dly_d = '0;
        if (en && ctrl_q[psrc_pkg::CTRL_SS_DONE]) rdy_d = psrc_pkg::RDY_WAIT;
      end
      psrc_pkg::RDY_WAIT: begin
        if (dly_q == RC'(READY_DELAY_CYC - 1)) begin
          if (ok) rdy_d = psrc_pkg::RDY_GOOD;
        end else begin
          dly_d = dly_q + 1'b1;
        end
      end
      psrc_pkg::RDY_GOOD: begin
        // a limit or overcurrent loss restarts the whole delay
        if (!ok) begin
          rdy_d = psrc_pkg::RDY_WAIT;
          dly_d = '0;
        end
      end
    endcase
    if (!en || !ctrl_q[psrc_pkg::CTRL_SS_DONE]) rdy_d = psrc_pkg::RDY_OFF;
    // open drain: low unless good, never driven high
    rdy_oe_d = (rdy_d != psrc_pkg::RDY_GOOD);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdy_q <= psrc_pkg::RDY_OFF;
      dly_q <= '0;
      rdy_oe_q <= 1'b1;
    end else begin
      rdy_q <= rdy_d;
      dly_q <= dly_d;
      rdy_oe_q <= rdy_oe_d;
    end
  end

  // ==========================================================
  // power state, channels and interrupt events
  // straps and the hold-off keep running while disabled, so enable
  // alone never restarts the light-load wait
  always_comb begin
    ll_d = ll_q;
    if (!en || !sif.host_rst_n || sif.psi_n) ll_d = 1'b0;
    else if (holdoff_done) ll_d = 1'b1;
    ref_d = en ? st2_q[7:0] : 8'h00;
    coupled_d = st2_q[SB_COUPLED];
    ldo_sel_d = st2_q[SB_LDO] ? psrc_pkg::LDO_775 : psrc_pkg::LDO_575;
    chen_d = CH_NONE;
    if (en) begin
      chen_d = st2_q[SB_TWO_PHASE] ? CH_TWO : CH_ALL;
      // follow the new state so channels and ldo switch on the same edge
      if (ll_d) chen_d = CH_ONE;
    end
    ldo_on_d = en & ll_d;
    ccm_d = en & ~ll_d;
    ev = '0;
    ev[psrc_pkg::IRQ_READY_RISE] = rdy_oe_q & ~rdy_oe_d;
    ev[psrc_pkg::IRQ_READY_FALL] = ~rdy_oe_q & rdy_oe_d;
    ev[psrc_pkg::IRQ_LL_ENTER] = ~ll_q & ll_d;
    ev[psrc_pkg::IRQ_LL_EXIT] = ll_q & ~ll_d;
    irq_d = |(ist_d & imask_d);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ll_q <= 1'b0;
      ref_q <= 8'h00;
      chen_q <= CH_NONE;
      ldo_sel_q <= psrc_pkg::LDO_575;
      coupled_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ll_q <= ll_d;
      ref_q <= ref_d;
      chen_q <= chen_d;
      ldo_sel_q <= ldo_sel_d;
      coupled_q <= coupled_d;
      irq_q <= irq_d;
    end
  end

  assign status = {holdoff_done, ldo_sel_q, ~rdy_oe_q, ll_q, st2_q[10], coupled_q, en};

  // ==========================================================
  // outputs
  logic ldo_on_q, ccm_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ldo_on_q <= 1'b0;
      ccm_q <= 1'b0;
    end else begin
      ldo_on_q <= ldo_on_d;
      ccm_q <= ccm_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign regulator_ready_o = 1'b0;
  assign regulator_ready_oe = rdy_oe_q;
  assign ref_code = ref_q;
  assign driver1_ldo_sel = ldo_sel_q;
  assign driver1_ldo_on = ldo_on_q;
  assign channel_enable = chen_q;
  assign ccm_mode = ccm_q;
  assign coupled_mode = coupled_q;
  assign irq = irq_q;

endmodule : psrc_top

// File: psrc_top_props.sv
// psrc_top_props: port-level checker for psrc_top, bound below.
// assumes one hclk domain and the 3-edge pin latency of the top.
`timescale 1ns/1ps
module psrc_top_props #(
  parameter int unsigned READY_DELAY_CYC = psrc_pkg::READY_DELAY_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable,
  input wire logic frequency_set_strap,
  input wire logic softstart_strap,
  input wire logic phase3_sense_neg,
  input wire logic [7:0] voltage_code_inputs,
  input wire logic [7:0] voltage_code_oe,
  input wire logic power_state_hint,
  input wire logic host_reset_n,
  input wire logic regulator_ready_o,
  input wire logic regulator_ready_oe,
  input wire logic [7:0] ref_code,
  input wire logic driver1_ldo_sel,
  input wire logic driver1_ldo_on,
  input wire logic [2:0] channel_enable,
  input wire logic ccm_mode,
  input wire logic coupled_mode
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // sequences
  sequence s_dis; !enable [*4]; endsequence
  sequence s_hrst_low; !host_reset_n [*4]; endsequence
  sequence s_run_hi; (enable && power_state_hint && $stable(phase3_sense_neg)) [*4]; endsequence
  // ==========================================================
  // properties
  property p_od; regulator_ready_o == 1'b0; endproperty
  property p_dis; s_dis |-> regulator_ready_oe && channel_enable == 3'h0; endproperty
  // unbroken cycles of the line pulled low, saturating at the delay
  logic [31:0] hold_cnt_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_cnt_q <= 32'h0;
    end else if (!regulator_ready_oe) begin
      hold_cnt_q <= 32'h0;
    end else if (hold_cnt_q < READY_DELAY_CYC) begin
      hold_cnt_q <= hold_cnt_q + 32'h1;
    end
  end
  property p_rdy_delay;
    $fell(regulator_ready_oe) |-> hold_cnt_q >= READY_DELAY_CYC;
  endproperty
  property p_no_ll; s_hrst_low |-> !driver1_ldo_on; endproperty
  // a lone glitch may vanish in the synchroniser, so a real low is required first
  property p_holdoff; s_hrst_low ##1 host_reset_n |-> !driver1_ldo_on [*8]; endproperty
  property p_ll; driver1_ldo_on |-> channel_enable == 3'h1 && !ccm_mode; endproperty
  property p_phases;
    s_run_hi |-> ccm_mode && channel_enable == (phase3_sense_neg ? 3'h3 : 3'h7);
  endproperty
  property p_coupled;
    (enable && $stable(frequency_set_strap)) [*4] |-> coupled_mode == frequency_set_strap;
  endproperty
  property p_ldo; $stable(softstart_strap) [*4] |-> driver1_ldo_sel == softstart_strap; endproperty
  property p_code;
    (enable && $stable(voltage_code_inputs) && $stable(voltage_code_oe)) [*4]
      |-> ref_code == (voltage_code_inputs | ~voltage_code_oe);
  endproperty
  a_od: assert property (p_od) else $error("ready line driven high");
  a_dis: assert property (p_dis) else $error("disabled but active");
  a_rdy_delay: assert property (p_rdy_delay) else $error("ready too early");
  a_no_ll: assert property (p_no_ll) else $error("light load in host reset");
  a_holdoff: assert property (p_holdoff) else $error("hold-off skipped");
  a_ll: assert property (p_ll) else $error("light load channels wrong");
  a_phases: assert property (p_phases) else $error("normal channels wrong");
  a_coupled: assert property (p_coupled) else $error("inductor mode wrong");
  a_ldo: assert property (p_ldo) else $error("ldo level wrong");
  a_code: assert property (p_code) else $error("reference code wrong");
endmodule // psrc_top_props

bind psrc_top psrc_top_props #(.READY_DELAY_CYC(READY_DELAY_CYC)) u_props (
  .hclk(hclk), .hresetn(hresetn), .enable(enable),
  .frequency_set_strap(frequency_set_strap), .softstart_strap(softstart_strap),
  .phase3_sense_neg(phase3_sense_neg), .voltage_code_inputs(voltage_code_inputs),
  .voltage_code_oe(voltage_code_oe), .power_state_hint(power_state_hint),
  .host_reset_n(host_reset_n), .regulator_ready_o(regulator_ready_o),
  .regulator_ready_oe(regulator_ready_oe), .ref_code(ref_code),
  .driver1_ldo_sel(driver1_ldo_sel), .driver1_ldo_on(driver1_ldo_on),
  .channel_enable(channel_enable), .ccm_mode(ccm_mode), .coupled_mode(coupled_mode));

// File: psrc_host_model.sv
// psrc_host_model: host platform driving the power hint and host reset.
// assumes requests from the bench; answers after lag cycles, 0 = prompt.
`timescale 1ns/1ps
module psrc_host_model (
  input wire logic hclk,
  input wire logic rst_req,
  input wire logic ll_req,
  input wire logic [1:0] lag,
  output logic power_state_hint,
  output logic host_reset_n
);
  logic [1:0] cnt_q;
  initial begin
    power_state_hint = 1'b1;
    host_reset_n = 1'b0;
    cnt_q = 2'h0;
  end
  // ==========================================================
  // pins move together once the lag has run out
  always @(posedge hclk) begin
    if (host_reset_n == rst_req || power_state_hint == ll_req) begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q >= lag) begin
        host_reset_n <= !rst_req;
        power_state_hint <= !ll_req;
        cnt_q <= 2'h0;
      end
    end else begin
      cnt_q <= 2'h0;
    end
  end
endmodule // psrc_host_model

// File: psrc_top_tb.sv
// psrc_top_tb: self-checking bench for psrc_top with the host model.
// assumes zero-wait AHB-Lite slave; short hold-off and ready delay.
`timescale 1ns/1ps
module psrc_top_tb;
  logic hclk, hresetn, hsel, hwrite, enable, fs, ss, p3, rst_req, ll_req, rd_dp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, lag;
  logic [7:0] code, oe, ref_code;
  logic hreadyout, hresp, psh, hrn, rdy_o, rdy_oe, ldo_sel, ldo_on, ccm, cpl, irq;
  logic [2:0] chan;
  logic [31:0] exp_q[$];
  int err_count, checked, n;
  psrc_top #(.HOLDOFF_CYC(20), .READY_DELAY_CYC(5)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .enable(enable), .frequency_set_strap(fs), .softstart_strap(ss), .phase3_sense_neg(p3),
    .voltage_code_inputs(code), .voltage_code_oe(oe), .power_state_hint(psh),
    .host_reset_n(hrn), .regulator_ready_o(rdy_o), .regulator_ready_oe(rdy_oe),
    .ref_code(ref_code), .driver1_ldo_sel(ldo_sel), .driver1_ldo_on(ldo_on),
    .channel_enable(chan), .ccm_mode(ccm), .coupled_mode(cpl), .irq(irq));
  psrc_host_model host (.hclk(hclk), .rst_req(rst_req), .ll_req(ll_req), .lag(lag),
    .power_state_hint(psh), .host_reset_n(hrn));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // ==========================================================
  // checks and bus
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // the read expectation is queued here and compared by the monitor below
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= 2'h2; hwrite <= w;
    if (!w) exp_q.push_back(d);
    @(posedge hclk); while (!hreadyout) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d; rd_dp <= !w;
    @(posedge hclk); while (!hreadyout) @(posedge hclk);
    rd_dp <= 1'b0;
  endtask
  always @(posedge hclk) begin
    if (rd_dp) begin
      chk("hrdata", exp_q.pop_front(), hrdata);
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("hreadyout", 32'h1, {31'h0, hreadyout});
    end
  end
  task automatic final_report;
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(25ns * 8000);
    err_count++;
    final_report();
  end
  // ==========================================================
  // scenarios
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hwdata = 32'h0; rd_dp = 1'b0; enable = 1'b0; fs = 1'b1; ss = 1'b1; p3 = 1'b0;
    code = 8'h00; oe = 8'hFF; rst_req = 1'b0; ll_req = 1'b0; lag = 2'h0;
    err_count = 0; checked = 0;
    void'($urandom(33));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    // let the strap flops flush their all-ones reset value first
    repeat (4) @(posedge hclk);
    bus(8'h04, 1'b0, 32'h22);
    bus(8'h20, 1'b0, 32'h0);
    chk("ready_oe", 32'h1, rdy_oe);
    enable <= 1'b1;
    repeat (4) begin
      code <= 8'($urandom); oe <= 8'($urandom); lag <= 2'($urandom);
      repeat (30) @(posedge hclk);
      chk("ref_code", {24'h0, code | ~oe}, ref_code);
      bus(8'h10, 1'b0, {24'h0, code | ~oe});
    end
    bus(8'h04, 1'b0, 32'h63);
    bus(8'h0C, 1'b1, 32'hF);
    bus(8'h00, 1'b1, 32'h3);
    repeat (4) @(posedge hclk);
    chk("ready_oe", 32'h1, rdy_oe);
    for (n = 0; n < 20 && rdy_oe; n++) @(posedge hclk);
    chk("ready_oe", 32'h0, rdy_oe);
    chk("irq", 32'h1, irq);
    bus(8'h08, 1'b0, 32'h1);
    bus(8'h08, 1'b1, 32'h1);
    @(posedge hclk);
    chk("irq", 32'h0, irq);
    bus(8'h00, 1'b1, 32'h7);
    repeat (4) @(posedge hclk);
    chk("ready_oe", 32'h1, rdy_oe);
    bus(8'h08, 1'b0, 32'h2);
    bus(8'h0C, 1'b1, 32'h0);
    bus(8'h08, 1'b1, 32'h2);
    bus(8'h00, 1'b1, 32'h3);
    repeat (15) @(posedge hclk);
    chk("irq", 32'h0, irq);
    bus(8'h08, 1'b0, 32'h1);
    rst_req <= 1'b1; ll_req <= 1'b1;
    repeat (30) @(posedge hclk);
    chk("ldo_on", 32'h0, ldo_on);
    rst_req <= 1'b0;
    @(posedge hrn);
    repeat (16) @(posedge hclk);
    chk("ldo_on", 32'h0, ldo_on);
    repeat (14) @(posedge hclk);
    chk("chan", 32'h1, {ccm, chan});
    chk("ldo_on", 32'h1, ldo_on);
    ll_req <= 1'b0;
    repeat (10) @(posedge hclk);
    chk("chan", 32'hF, {ccm, chan});
    ll_req <= 1'b1;
    repeat (10) @(posedge hclk);
    chk("ldo_on", 32'h1, ldo_on);
    ll_req <= 1'b0; fs <= 1'b0; ss <= 1'b0; p3 <= 1'b1;
    repeat (10) @(posedge hclk);
    chk("chan", 32'h3, {cpl, ldo_sel, chan});
    enable <= 1'b0;
    repeat (6) @(posedge hclk);
    chk("off", 32'h800, {rdy_oe, ref_code, chan});
    final_report();
  end
endmodule // psrc_top_tb
